// ---- src/atc_pkg.sv ----
// Purpose: shared constants and types for the threshold compare and status block
// Assumes: 16-bit two's complement converter values, 16-bit register port
// Notes:   register indices are word addresses on the plain register port
package atc_pkg;

  localparam int DW     = 16;
  localparam int AW     = 3;
  localparam int CALC_W = DW + 2;
  localparam int BYTE_W = 8;

  // register indices
  localparam logic [AW-1:0] ADDR_CTRL = 3'h0;
  localparam logic [AW-1:0] ADDR_STAT = 3'h1;
  localparam logic [AW-1:0] ADDR_RUN  = 3'h2;
  localparam logic [AW-1:0] ADDR_UTH  = 3'h3;
  localparam logic [AW-1:0] ADDR_LTH  = 3'h4;
  localparam logic [AW-1:0] ADDR_STPT = 3'h5;
  localparam logic [AW-1:0] ADDR_ERR  = 3'h6;

  // threshold irq modes
  localparam logic [2:0] TMD_OFF     = 3'h0;
  localparam logic [2:0] TMD_BELOW   = 3'h1;
  localparam logic [2:0] TMD_GE_LO   = 3'h2;
  localparam logic [2:0] TMD_INSIDE  = 3'h3;
  localparam logic [2:0] TMD_OUTSIDE = 3'h4;
  localparam logic [2:0] TMD_LE_UP   = 3'h5;
  localparam logic [2:0] TMD_ABOVE   = 3'h6;
  localparam logic [2:0] TMD_ALWAYS  = 3'h7;

  // error calculation selects
  localparam logic [2:0] CALC_RES_PREV  = 3'h0;
  localparam logic [2:0] CALC_RES_STPT  = 3'h1;
  localparam logic [2:0] CALC_RES_FILT  = 3'h2;
  localparam logic [2:0] CALC_PREV_FILT = 3'h4;
  localparam logic [2:0] CALC_FILT_STPT = 3'h5;

  typedef struct packed {
    logic       rsv;
    logic [2:0] calc;
    logic       soi;
    logic [2:0] tmd;
  } atc_ctrl_t;

  typedef struct packed {
    logic       aov;
    logic       uthr;
    logic       lthr;
    logic       math;
    logic       rsv;
    logic [2:0] stage;
  } atc_stat_t;

  typedef struct packed {
    logic [2:0] rsv;
    logic       aclr;
    logic       tif;
    logic       psis;
    logic       cont;
    logic       go;
  } atc_run_t;

  typedef struct packed {
    logic [DW-1:0] result;
    logic [DW-1:0] previous;
    logic [DW-1:0] sample1;
    logic [DW-1:0] sample2;
    logic [DW-1:0] filtered;
    logic          double_sample;
    logic          calc_done;
    logic          accum_update;
    logic          accum_overflow;
    logic          clear_done;
    logic [2:0]    stage;
  } atc_core_in_t;

  typedef struct packed {
    atc_ctrl_t     ctrl;
    atc_stat_t     stat;
    atc_run_t      run;
    logic [DW-1:0] uth;
    logic [DW-1:0] lth;
    logic [DW-1:0] stpt;
    logic [DW-1:0] err;
    logic          retrig;
    logic [DW-1:0] rdata;
  } atc_state_t;

  localparam atc_state_t STATE_RESET = '0;

endpackage

// ---- src/atc_core.sv ----
// Purpose: error computation, threshold compare, retrigger control and status
// Assumes: converter core inputs are on clk_in; calc_done is a one-cycle pulse
// Notes:   all state freezes while clk_en_in is low
//
// Overview of operation
// R1: continuous with stop-on-threshold: hit clears go, else retrigger
// R2: stop-on-threshold off: only software clears go
// R3: continuous off: stop-on-threshold ignored
// R4: mode 111 always sets flag; 000 never
// R5: mode 110 above upper; 101 at/below upper
// R6: mode 100 outside window; 011 strictly inside
// R7: mode 010 at/above lower; 001 below lower
// R8: source select 0 uses second minus first sample
// R9: updates set computation flag; software clears it
// R10: computation flag stays clear without updates
// R11: read-only above, below and overflow flags
// R12: three-bit read-only conversion stage field
// R13: error value per calculation select
// R14: clear command clears overflow; hardware ends it
`timescale 1ns/1ps
`default_nettype none

module atc_core (
  input  wire logic                      clk_in,
  input  wire logic                      sys_rst_in,
  input  wire logic                      clk_en_in,
  input  wire logic [atc_pkg::AW-1:0]    addr_in,
  input  wire logic [atc_pkg::DW-1:0]    wdata_in,
  input  wire logic                      wr_in,
  input  wire logic                      rd_in,
  output logic      [atc_pkg::DW-1:0]    rdata_out,
  input  wire atc_pkg::atc_core_in_t     core_in,
  output logic                           conversion_go_out,
  output logic                           retrigger_out,
  output logic                           accum_clear_cmd_out,
  output logic                           threshold_irq_flag_out,
  output logic      [atc_pkg::DW-1:0]    error_value_out
);

  ////////////////////////////////////////////////////////////////////////////
  // decode helpers

  function automatic logic signed [atc_pkg::CALC_W-1:0] sx(
    input logic [atc_pkg::DW-1:0] v);
    return atc_pkg::CALC_W'($signed(v));
  endfunction

  function automatic logic thr_hit(
    input logic [2:0]                  mode,
    input logic signed [atc_pkg::DW-1:0] e,
    input logic signed [atc_pkg::DW-1:0] up,
    input logic signed [atc_pkg::DW-1:0] lo);
    logic h;
    h = 1'b0;
    case (mode)
      atc_pkg::TMD_ALWAYS:  h = 1'b1;                   // R4
      atc_pkg::TMD_ABOVE:   h = (e > up);               // R5
      atc_pkg::TMD_LE_UP:   h = (e <= up);              // R5
      atc_pkg::TMD_OUTSIDE: h = (e < lo) || (e > up);   // R6
      atc_pkg::TMD_INSIDE:  h = (e > lo) && (e < up);   // R6
      atc_pkg::TMD_GE_LO:   h = (e >= lo);              // R7
      atc_pkg::TMD_BELOW:   h = (e < lo);               // R7
      default:              h = 1'b0;                   // R4
    endcase
    return h;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // state

  atc_pkg::atc_state_t st_reg;
  atc_pkg::atc_state_t st_next;

  logic signed [atc_pkg::CALC_W-1:0] rmp;
  logic signed [atc_pkg::CALC_W-1:0] err_wide;
  logic signed [atc_pkg::DW-1:0]     err_calc;
  logic                              err_ovf;
  logic                              hit;
  logic                              cmp_above;
  logic                              cmp_below;
  logic                              wr_ctrl;
  logic                              wr_stat;
  logic                              wr_run;
  logic                              wr_thr;
  logic                              aov_set;
  logic                              math_set;
  atc_pkg::atc_run_t                 run_w;
  atc_pkg::atc_stat_t                stat_w;

  ////////////////////////////////////////////////////////////////////////////
  // error computation

  always_comb begin
    // result-minus-previous term when psis is set; with psis clear it is sample2 minus sample1
    if (st_reg.run.psis) begin
      rmp = sx(core_in.result) - sx(core_in.previous);
    end else begin
      rmp = sx(core_in.sample2) - sx(core_in.sample1); // R8
    end
    case (st_reg.ctrl.calc)                                   // R13
      atc_pkg::CALC_RES_PREV:  err_wide = rmp;
      atc_pkg::CALC_RES_STPT:  err_wide = core_in.double_sample ?
                                 rmp - sx(st_reg.stpt) :
                                 sx(core_in.result) - sx(st_reg.stpt);
      atc_pkg::CALC_RES_FILT:  err_wide = core_in.double_sample ?
                                 rmp - sx(core_in.filtered) :
                                 sx(core_in.result) - sx(core_in.filtered);
      atc_pkg::CALC_PREV_FILT: err_wide = sx(core_in.previous) - sx(core_in.filtered);
      atc_pkg::CALC_FILT_STPT: err_wide = sx(core_in.filtered) - sx(st_reg.stpt);
      default:                 err_wide = '0;  // reserved selects give zero
    endcase
  end

  assign err_calc  = err_wide[atc_pkg::DW-1:0];
  // wrapped value is kept; software sees the overflow flag instead
  assign err_ovf   = (err_wide != sx(err_calc));
  assign hit       = thr_hit(st_reg.ctrl.tmd, err_calc, st_reg.uth, st_reg.lth);
  assign cmp_above = (err_calc > $signed(st_reg.uth));
  assign cmp_below = (err_calc < $signed(st_reg.lth));

  ////////////////////////////////////////////////////////////////////////////
  // register port decode

  assign wr_ctrl  = wr_in && (addr_in == atc_pkg::ADDR_CTRL);
  assign wr_stat  = wr_in && (addr_in == atc_pkg::ADDR_STAT);
  assign wr_run   = wr_in && (addr_in == atc_pkg::ADDR_RUN);
  assign wr_thr   = wr_in && ((addr_in == atc_pkg::ADDR_UTH) ||
                              (addr_in == atc_pkg::ADDR_LTH));
  assign run_w    = atc_pkg::atc_run_t'(wdata_in[atc_pkg::BYTE_W-1:0]);
  assign stat_w   = atc_pkg::atc_stat_t'(wdata_in[atc_pkg::BYTE_W-1:0]);
  assign aov_set  = core_in.accum_overflow || (core_in.calc_done && err_ovf);
  assign math_set = core_in.calc_done || core_in.accum_update || aov_set || wr_thr; // R9

  ////////////////////////////////////////////////////////////////////////////
  // next state

  always_comb begin
    st_next = st_reg;
    st_next.retrig = 1'b0;
    st_next.rdata  = '0;
    st_next.stat.stage = core_in.stage;                       // R12
    st_next.stat.rsv   = 1'b0;
    st_next.ctrl.rsv   = 1'b0;
    st_next.run.rsv    = '0;

    if (wr_ctrl) begin
      st_next.ctrl     = atc_pkg::atc_ctrl_t'(wdata_in[atc_pkg::BYTE_W-1:0]);
      st_next.ctrl.rsv = 1'b0;
    end
    if (wr_in && addr_in == atc_pkg::ADDR_UTH) begin
      st_next.uth = wdata_in;
    end
    if (wr_in && addr_in == atc_pkg::ADDR_LTH) begin
      st_next.lth = wdata_in;
    end
    if (wr_in && addr_in == atc_pkg::ADDR_STPT) begin
      st_next.stpt = wdata_in;
    end

    // end of calculation: error, compare flags, go handling
    if (core_in.calc_done) begin
      st_next.err       = err_calc;                           // R13
      st_next.stat.uthr = cmp_above;                          // R11
      st_next.stat.lthr = cmp_below;                          // R11
      if (st_reg.run.go) begin
        if (!st_reg.run.cont) begin
          st_next.run.go = 1'b0;                              // R3
        end else if (st_reg.ctrl.soi && hit) begin
          st_next.run.go = 1'b0;                              // R1
        end else begin
          st_next.retrig = 1'b1;                              // R2
        end
      end
    end

    // software run register; its go write overrides the hardware clear
    if (wr_run) begin
      st_next.run.go   = run_w.go;
      st_next.run.cont = run_w.cont;
      st_next.run.psis = run_w.psis;
      if (run_w.aclr) begin
        st_next.run.aclr = 1'b1;                              // R14
      end
    end

    // threshold flag: write one clears, a same-cycle set wins
    if (wr_run && run_w.tif) begin
      st_next.run.tif = 1'b0;
    end
    if (core_in.calc_done && hit) begin
      st_next.run.tif = 1'b1;                                 // R4
    end

    // accumulator clear handshake with the core
    if (st_reg.run.aclr && core_in.clear_done) begin
      st_next.run.aclr = 1'b0;                                // R14
      st_next.stat.aov = 1'b0;                                // R14
    end
    if (aov_set) begin
      st_next.stat.aov = 1'b1;                                // R11
    end

    // computation flag: write zero clears, a same-cycle update wins
    if (wr_stat && !stat_w.math) begin
      st_next.stat.math = 1'b0;                               // R10
    end
    if (math_set) begin
      st_next.stat.math = 1'b1;                               // R9
    end

    if (rd_in) begin
      case (addr_in)
        atc_pkg::ADDR_CTRL: st_next.rdata = atc_pkg::DW'(st_reg.ctrl);
        atc_pkg::ADDR_STAT: st_next.rdata = atc_pkg::DW'(st_reg.stat);
        atc_pkg::ADDR_RUN:  st_next.rdata = atc_pkg::DW'(st_reg.run);
        atc_pkg::ADDR_UTH:  st_next.rdata = st_reg.uth;
        atc_pkg::ADDR_LTH:  st_next.rdata = st_reg.lth;
        atc_pkg::ADDR_STPT: st_next.rdata = st_reg.stpt;
        atc_pkg::ADDR_ERR:  st_next.rdata = st_reg.err;
        default:            st_next.rdata = '0;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // registers; enable low freezes everything

  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      st_reg <= atc_pkg::STATE_RESET;
    end else if (clk_en_in) begin
      st_reg <= st_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs straight from the state register

  assign rdata_out              = st_reg.rdata;
  assign conversion_go_out      = st_reg.run.go;
  assign retrigger_out          = st_reg.retrig;
  assign accum_clear_cmd_out    = st_reg.run.aclr;
  assign threshold_irq_flag_out = st_reg.run.tif;
  assign error_value_out        = st_reg.err;

  ////////////////////////////////////////////////////////////////////////////
  // checks; a software go write wins, so it is left out of the go checks

  default clocking cb_main @(posedge clk_in);
  endclocking
  default disable iff (sys_rst_in);

  property p_go_stop_hit;
    clk_en_in && core_in.calc_done && st_reg.run.go && st_reg.run.cont && st_reg.ctrl.soi && hit && !wr_run |=> !conversion_go_out;
  endproperty
  a_go_stop_hit: assert property (p_go_stop_hit) // R1
    else $error("go not cleared on threshold hit");

  property p_go_retrig;
    clk_en_in && core_in.calc_done && st_reg.run.go && st_reg.run.cont && !(st_reg.ctrl.soi && hit) |=> retrigger_out;
  endproperty
  a_go_retrig: assert property (p_go_retrig) // R1
    else $error("no retrigger after a miss");

  property p_go_keep;
    clk_en_in && core_in.calc_done && st_reg.run.go && st_reg.run.cont && !st_reg.ctrl.soi && !wr_run |=> conversion_go_out;
  endproperty
  a_go_keep: assert property (p_go_keep) // R2
    else $error("go cleared with stop-on-threshold off");

  property p_single_stop;
    clk_en_in && core_in.calc_done && st_reg.run.go && !st_reg.run.cont && !wr_run |=> !conversion_go_out && !retrigger_out;
  endproperty
  a_single_stop: assert property (p_single_stop) // R3
    else $error("single conversion did not end");

  property p_tif_always;
    clk_en_in && core_in.calc_done && st_reg.ctrl.tmd == atc_pkg::TMD_ALWAYS |=> threshold_irq_flag_out;
  endproperty
  a_tif_always: assert property (p_tif_always) // R4
    else $error("flag not set in always mode");

  property p_tif_off;
    clk_en_in && st_reg.ctrl.tmd == atc_pkg::TMD_OFF && !threshold_irq_flag_out |=> !threshold_irq_flag_out;
  endproperty
  a_tif_off: assert property (p_tif_off) // R4
    else $error("flag set in disabled mode");

  property p_tif_above;
    clk_en_in && core_in.calc_done && !wr_thr && st_reg.ctrl.tmd == atc_pkg::TMD_ABOVE |=> !($signed(st_reg.err) > $signed(st_reg.uth)) || threshold_irq_flag_out;
  endproperty
  a_tif_above: assert property (p_tif_above) // R5
    else $error("flag missing above upper");

  property p_tif_inside;
    clk_en_in && core_in.calc_done && !wr_thr && st_reg.ctrl.tmd == atc_pkg::TMD_INSIDE |=> !($signed(st_reg.err) > $signed(st_reg.lth) && $signed(st_reg.err) < $signed(st_reg.uth)) || threshold_irq_flag_out;
  endproperty
  a_tif_inside: assert property (p_tif_inside) // R6
    else $error("flag missing inside window");

  property p_above_flag;
    clk_en_in && core_in.calc_done && !wr_thr |=> st_reg.stat.uthr == ($signed(st_reg.err) > $signed(st_reg.uth));
  endproperty
  a_above_flag: assert property (p_above_flag) // R11
    else $error("above flag disagrees with error");

  property p_math_set;
    clk_en_in && math_set |=> st_reg.stat.math;
  endproperty
  a_math_set: assert property (p_math_set) // R9
    else $error("computation flag not set");

  property p_math_hold;
    clk_en_in && !math_set && !st_reg.stat.math |=> !st_reg.stat.math;
  endproperty
  a_math_hold: assert property (p_math_hold) // R10
    else $error("computation flag set without update");

  property p_aclr_clear;
    clk_en_in && st_reg.run.aclr && core_in.clear_done && !aov_set && !wr_run |=> !accum_clear_cmd_out && !st_reg.stat.aov;
  endproperty
  a_aclr_clear: assert property (p_aclr_clear) // R14
    else $error("clear command not ended");

  property p_stage;
    clk_en_in |=> st_reg.stat.stage == $past(core_in.stage);
  endproperty
  a_stage: assert property (p_stage) // R12
    else $error("stage field lags the core");

  property p_freeze;
    !clk_en_in |=> $stable(st_reg);
  endproperty
  a_freeze: assert property (p_freeze)
    else $error("state moved while disabled");

  c_stop_hit: cover property (core_in.calc_done && st_reg.run.go && st_reg.run.cont && st_reg.ctrl.soi && hit);
  c_retrig: cover property (retrigger_out);
  c_clear_done: cover property (st_reg.run.aclr && core_in.clear_done);
  c_tif_set: cover property (!threshold_irq_flag_out ##1 threshold_irq_flag_out);

endmodule
`default_nettype wire

// ---- verification/atc_conv_model.sv ----
// Purpose: converter core stand-in for the compare block
// Assumes: calc_done pulses one cycle after the last stage
// Notes:   clr_wait sets how slowly a clear is answered
`timescale 1ns/1ps
`default_nettype none
module atc_conv_model (
  input  wire logic                  clk_in,
  input  wire logic                  accum_clear_cmd_in,
  output var  atc_pkg::atc_core_in_t core_out
);
  int clr_wait = 1;
  int clr_cnt  = 0;
  initial core_out = '0;
  // stage codes walk first then second sample
  task automatic calc(input logic [15:0] res, input logic [15:0] s1,
                      input logic [15:0] s2, input logic dbl);
    for (int s = 1; s < 8; s++) begin
      @(posedge clk_in);
      if (s != 4 && (dbl || s < 4)) begin
        core_out.stage <= s[2:0];
      end
    end
    @(posedge clk_in);
    core_out.stage <= 3'h0;
    core_out.result <= res;
    core_out.sample1 <= s1;
    core_out.sample2 <= s2;
    core_out.double_sample <= dbl;
    core_out.calc_done <= 1'b1;
    @(posedge clk_in);
    core_out.calc_done <= 1'b0;
  endtask
  task automatic upd();
    @(posedge clk_in);
    core_out.accum_update <= 1'b1;
    @(posedge clk_in);
    core_out.accum_update <= 1'b0;
  endtask
  // clear answered late on purpose, a pulse once done
  always @(posedge clk_in) begin
    core_out.clear_done <= 1'b0;
    if (accum_clear_cmd_in && !core_out.clear_done) begin
      clr_cnt <= clr_cnt + 1;
      if (clr_cnt >= clr_wait) begin
        core_out.clear_done <= 1'b1;
        clr_cnt <= 0;
      end
    end
  end
endmodule
`default_nettype wire

// ---- verification/adc_threshold_compare_status_bench.sv ----
// Purpose: self-checking bench for the compare block
// Assumes: results settle within three cycles of calc_done
// Notes:   expectations come from integer models here
`timescale 1ns/1ps
`default_nettype none
module adc_threshold_compare_status_bench;
  logic clk_in = 1'b0;
  logic sys_rst_in = 1'b1;
  logic [2:0] addr = 3'h0;
  logic [15:0] wdata = 16'h0000;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [15:0] rdata, err_o;
  logic go_o, rt_o, clr_o, tif_o;
  atc_pkg::atc_core_in_t core;
  int miscompares = 0;
  int checks_done = 0;
  int rt_cnt = 0;
  always #4 clk_in = ~clk_in;
  always @(posedge clk_in) if (rt_o === 1'b1) rt_cnt++;
  atc_core i_dut (.clk_in(clk_in), .sys_rst_in(sys_rst_in), .clk_en_in(1'b1),
    .addr_in(addr), .wdata_in(wdata), .wr_in(wr), .rd_in(rd), .rdata_out(rdata),
    .core_in(core), .conversion_go_out(go_o), .retrigger_out(rt_o),
    .accum_clear_cmd_out(clr_o), .threshold_irq_flag_out(tif_o),
    .error_value_out(err_o));
  atc_conv_model i_conv (.clk_in(clk_in), .accum_clear_cmd_in(clr_o), .core_out(core));
  ////////////////////////////////////////////////////////////////////////
  task automatic end_sim();
    $display("checks %0d mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp) begin
      miscompares++;
      $display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic wr_reg(input logic [2:0] a, input logic [15:0] d);
    @(posedge clk_in);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk_in);
    wr <= 1'b0;
  endtask
  task automatic rd_reg(input logic [2:0] a, output logic [15:0] d);
    @(posedge clk_in);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk_in);
    rd <= 1'b0;
    #1 d = rdata;
  endtask
  function automatic logic hit(int m, int e, int u, int l);
    logic [7:0] t;
    t = {1'b1, e > u, e <= u, e < l || e > u, e > l && e < u, e >= l, e < l, 1'b0};
    return t[m];
  endfunction
  ////////////////////////////////////////////////////////////////////////
  initial begin
    logic [15:0] r;
    int e, u, l, sp, res, c;
    void'($urandom(32'hf954069f));
    repeat (6) @(posedge clk_in);
    sys_rst_in <= 1'b0;
    for (int a = 0; a < 3; a++) begin
      rd_reg(a[2:0], r);
      chk(r, 16'h0000);
    end
    // every mode, boundaries on the first two passes
    for (int m = 0; m < 8; m++) begin
      for (int k = 0; k < 3; k++) begin
        u = int'($urandom_range(400)) - 200;
        l = u - int'($urandom_range(300));
        sp = int'($urandom_range(200)) - 100;
        e = (k == 0) ? u : (k == 1) ? l : int'($urandom_range(1000)) - 500;
        res = e + sp;
        wr_reg(atc_pkg::ADDR_UTH, u[15:0]);
        wr_reg(atc_pkg::ADDR_LTH, l[15:0]);
        wr_reg(atc_pkg::ADDR_STPT, sp[15:0]);
        wr_reg(atc_pkg::ADDR_CTRL, {9'h000, atc_pkg::CALC_RES_STPT, 1'b0, m[2:0]});
        wr_reg(atc_pkg::ADDR_RUN, 16'h0008);
        i_conv.calc(res[15:0], 16'h0000, 16'h0000, 1'b0);
        repeat (3) @(posedge clk_in);
        chk(err_o, e[15:0]);
        chk({15'h0000, tif_o}, {15'h0000, hit(m, e, u, l)});
        rd_reg(atc_pkg::ADDR_RUN, r);
        chk({15'h0000, r[3]}, {15'h0000, hit(m, e, u, l)});
        rd_reg(atc_pkg::ADDR_STAT, r);
        chk({14'h0000, r[6:5]}, {14'h0000, e > u, e < l});
      end
    end
    // double sample, second minus first
    u = int'($urandom_range(900));
    l = int'($urandom_range(900));
    wr_reg(atc_pkg::ADDR_CTRL, {9'h000, atc_pkg::CALC_RES_PREV, 4'h0});
    i_conv.calc(16'h0123, u[15:0], l[15:0], 1'b1);
    repeat (3) @(posedge clk_in);
    e = l - u;
    chk(err_o, e[15:0]);
    // cont, soi, mode: hit stops, miss or soi off retriggers
    for (int t = 0; t < 4; t++) begin
      c = (t == 3) ? 0 : 1;
      m_loop: begin
        logic s;
        logic [2:0] md;
        s = (t != 2);
        md = (t == 1) ? 3'h0 : 3'h7;
        wr_reg(atc_pkg::ADDR_CTRL, {9'h000, atc_pkg::CALC_RES_STPT, s, md});
        wr_reg(atc_pkg::ADDR_RUN, {14'h0000, c[0], 1'b1});
        rt_cnt = 0;
        i_conv.calc(16'h0010, 16'h0000, 16'h0000, 1'b0);
        repeat (3) @(posedge clk_in);
        if (c == 1) chk({15'h0000, go_o}, {15'h0000, !(s && md == 3'h7)});
        chk({15'h0000, rt_cnt > 0}, {15'h0000, c == 1 && !(s && md == 3'h7)});
      end
    end
    wr_reg(atc_pkg::ADDR_RUN, 16'h0000);
    wr_reg(atc_pkg::ADDR_STAT, 16'h0000);
    rd_reg(atc_pkg::ADDR_STAT, r);
    chk({15'h0000, r[4]}, 16'h0000);
    i_conv.upd();
    repeat (2) @(posedge clk_in);
    rd_reg(atc_pkg::ADDR_STAT, r);
    chk({15'h0000, r[4]}, 16'h0001);
    for (int s = 0; s < 8; s++) begin
      if (s != 4) begin
        @(posedge clk_in);
        i_conv.core_out.stage <= s[2:0];
        rd_reg(atc_pkg::ADDR_STAT, r);
        chk({13'h0000, r[2:0]}, {13'h0000, s[2:0]});
      end
    end
    i_conv.clr_wait = 5;
    wr_reg(atc_pkg::ADDR_RUN, 16'h0010);
    @(posedge clk_in);
    chk({15'h0000, clr_o}, 16'h0001);
    c = 0;
    while (clr_o !== 1'b0 && c < 30) begin
      @(posedge clk_in);
      c++;
    end
    chk({15'h0000, c < 30}, 16'h0001);
    end_sim();
  end
  initial begin
    #400000;
    miscompares++;
    end_sim();
  end
endmodule
`default_nettype wire
